// ===== dv/sdi_source_model.sv
// behavioural model of the two sdi sources feeding the receivers
`timescale 1ns/1ps
`default_nettype none
module sdi_source_model #(
   parameter int lock_cycles = 3
) (
   // clock
   input  wire logic       clk_in,
   // carrier present per receiver, bit 0 coaxial, bit 1 optical
   input  wire logic [1:0] on_in,
   input  wire logic [3:0] coax_fmt_req_in,
   input  wire logic [3:0] opt_fmt_req_in,
   // receiver indications
   output logic      [1:0] lock_out = 2'h0,
   output logic      [3:0] coax_fmt_out,
   output logic      [3:0] opt_fmt_out
);
   int   cnt [2] = '{0, 0};
   logic tog     = 1'b0;
   // lock only after lock_cycles of carrier, lost at once
   always_ff @(posedge clk_in) begin
      tog <= ~tog;
      for (int i = 0; i < 2; i++) begin
         cnt[i]      <= !on_in[i] ? 0 : (cnt[i] < lock_cycles ? cnt[i] + 1 : cnt[i]);
         lock_out[i] <= on_in[i] && (cnt[i] >= lock_cycles);
      end
   end
   // unlocked receivers give no stable format: garbage flips every cycle
   always_comb begin
      coax_fmt_out = lock_out[0] ? coax_fmt_req_in : ~coax_fmt_req_in ^ {4{tog}};
      opt_fmt_out  = lock_out[1] ? opt_fmt_req_in : ~opt_fmt_req_in ^ {4{tog}};
   end
endmodule
`default_nettype wire

// ===== dv/testbench.sv
// self-checking bench for the fallback output controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam int sec = 10;
   logic        clk_in, nrst_in, rd, wr, contact, waitreq, ref_lock, box_en, tx_en, cact;
   logic        lstat, irq;
   logic [1:0]  on, lk, src;
   logic [3:0]  addr, coax_fq, opt_fq, coax_fmt, opt_fmt, gfmt, f;
   logic [5:0]  s;
   logic [7:0]  bx, by;
   logic [15:0] pos;
   logic [31:0] wdata, rdata, rdo;
   int          fail_count = 0, n_checks = 0, cyc = 0, n;

   sdi_fallback_output_control #(.second_cycles(sec), .box_cycles(4)) dut (
      .clk_in(clk_in), .nrst_in(nrst_in), .avs_address_in(addr), .avs_read_in(rd),
      .avs_write_in(wr), .avs_writedata_in(wdata), .avs_readdata_out(rdo),
      .avs_waitrequest_out(waitreq), .coax_lock_in(lk[0]), .coax_fmt_in(coax_fmt),
      .opt_lock_in(lk[1]), .opt_fmt_in(opt_fmt), .contact_input_in(contact),
      .out_source_out(src), .gen_fmt_out(gfmt), .gen_ref_lock_out(ref_lock),
      .box_enable_out(box_en), .box_x_out(bx), .box_y_out(by),
      .optical_tx_enable_out(tx_en), .contact_active_out(cact),
      .lock_status_output_out(lstat), .irq_out(irq));
   sdi_source_model src_model (
      .clk_in(clk_in), .on_in(on), .coax_fmt_req_in(coax_fq), .opt_fmt_req_in(opt_fq),
      .lock_out(lk), .coax_fmt_out(coax_fmt), .opt_fmt_out(opt_fmt));

   // 20 MHz clock
   initial begin
      clk_in = 1'b0;
      forever #25 clk_in = ~clk_in;
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] act);
      n_checks++;
      if (act !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, exp, act);
      end
   endtask

   // one avalon transfer, held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_in);
      addr  <= a;
      wdata <= d;
      wr    <= w;
      rd    <= !w;
      n = 0;
      do begin
         @(posedge clk_in);
         n++;
      end while (waitreq !== 1'b0);
      rdata = rdo;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge clk_in);
   endtask

   function automatic logic [31:0] ctl(input logic so, fo, input logic [2:0] d,
                                       input logic ov, ro, po, input logic [3:0] fm);
      ctl = {20'h0, fm, po, ro, ov, d, fo, so};
   endfunction

   // pin level expected from lock and polarity
   function automatic logic exp_stat(input logic lock, pol);
      exp_stat = lock ^ pol;
   endfunction

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // hang guard, far above the roughly one thousand cycles the run needs
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 8000) begin
         fail_count++;
         report_and_stop();
      end
   end

   initial begin
      void'($urandom(32'h7B64E83A));
      {nrst_in, rd, wr, contact, on, addr, wdata} = '0;
      {coax_fq, opt_fq} = 8'h35;
      tick(8);
      nrst_in <= 1'b1;
      bus(0, sdi_fallback_pkg::ctrl_offset, 0);
      chk("ctrl reset", {20'h0, sdi_fallback_pkg::ctrl_reset}, rdata);
      bus(0, 4'h2, 0);
      chk("unmapped read", 0, rdata);
      chk("optical tx", 1, tx_en);
      $display("test reset done");
      // random selection, polarity, carriers and contact level
      for (int i = 0; i < 16; i++) begin
         s = 6'($urandom);
         bus(1, sdi_fallback_pkg::ctrl_offset, ctl(s[0], 1, 0, 1, 0, s[1], 0));
         on      <= s[3:2];
         contact <= s[4];
         tick(8);
         chk("lock status", exp_stat(lk[s[0]], s[1]), lstat);
         chk("contact", !s[4], cact);
         chk("source", lk[s[0]] ? 0 : 2, src);
      end
      $display("test select and polarity done");
      contact <= 1'b1;
      // loss, gray interval of every length, image, relock
      for (int d = 0; d < 8; d++) begin
         bus(1, sdi_fallback_pkg::ctrl_offset, ctl(0, 1, 3'(d), d[0], 0, 0, 0));
         bus(1, sdi_fallback_pkg::irq_en_offset, 32'h7);
         on <= 2'b01;
         tick(8);
         chk("pass", sdi_fallback_pkg::src_pass, src);
         bus(1, sdi_fallback_pkg::irq_clr_offset, 32'h7);
         chk("irq cleared", 0, irq);
         on <= 2'b00;
         n = 0;
         do begin
            @(posedge clk_in);
            n++;
         end while (src === sdi_fallback_pkg::src_pass && n < 10);
         chk("first fill", d == 0 ? 2 : 1, src);
         n = 0;
         while (src === sdi_fallback_pkg::src_gray && n < 100) begin
            @(posedge clk_in);
            n++;
         end
         chk("gray cycles", d * sec, n);
         chk("image", sdi_fallback_pkg::src_image, src);
         chk("loss irq", 1, irq);
         bus(0, sdi_fallback_pkg::status_offset, 0);
         chk("status", 8'h85, {rdata[7:6], 1'b0, rdata[4:0]});
         chk("box enable", d[0], box_en);
         pos = {bx, by};
         tick(40);
         if (d[0])
            chk("box moves", 1, pos !== {bx, by});
         on <= 2'b01;
         tick(6);
         chk("relock", sdi_fallback_pkg::src_pass, src);
      end
      $display("test fallback done");
      // format learned while locked, kept after loss, frozen in fixed mode
      f = 4'($urandom);
      bus(1, sdi_fallback_pkg::ctrl_offset, ctl(0, 1, 0, 1, 0, 0, ~f));
      coax_fq <= f;
      tick(8);
      chk("follow fmt", f, gfmt);
      on <= 2'b00;
      tick(8);
      chk("kept fmt", f, gfmt);
      bus(1, sdi_fallback_pkg::ctrl_offset, ctl(0, 0, 0, 1, 0, 0, f));
      coax_fq <= ~f;
      on      <= 2'b01;
      tick(8);
      chk("fixed fmt", f, gfmt);
      $display("test format done");
      // reference only: timing from input, content never passed
      bus(1, sdi_fallback_pkg::ctrl_offset, ctl(0, 1, 0, 1, 1, 0, 0));
      tick(8);
      chk("ref lock", 1, ref_lock);
      chk("ref source", sdi_fallback_pkg::src_image, src);
      on <= 2'b00;
      tick(4);
      chk("ref unlock", 0, ref_lock);
      $display("test reference done");
      report_and_stop();
   end
endmodule
`default_nettype wire

// ===== hdl/sdi_fallback_output_control.sv
// fallback output control: input select, gray interval, stored image, status
`timescale 1ns/1ps
`default_nettype none
module sdi_fallback_output_control #(
   parameter int second_cycles = sdi_fallback_pkg::second_cyc,
   parameter int box_cycles    = sdi_fallback_pkg::box_cyc,
   parameter int fmt_width     = 4,
   parameter int box_width     = 8
) (
   // clock and reset
   input  wire logic                 clk_in,
   input  wire logic                 nrst_in,
   // avalon-mm slave
   input  wire logic [3:0]           avs_address_in,
   input  wire logic                 avs_read_in,
   input  wire logic                 avs_write_in,
   input  wire logic [31:0]          avs_writedata_in,
   output logic      [31:0]          avs_readdata_out,
   output logic                      avs_waitrequest_out,
   // receivers
   input  wire logic                 coax_lock_in,
   input  wire logic [fmt_width-1:0] coax_fmt_in,
   input  wire logic                 opt_lock_in,
   input  wire logic [fmt_width-1:0] opt_fmt_in,
   // contact input, pin level
   input  wire logic                 contact_input_in,
   // generator and output control
   output logic      [1:0]           out_source_out,
   output logic      [fmt_width-1:0] gen_fmt_out,
   output logic                      gen_ref_lock_out,
   output logic                      box_enable_out,
   output logic      [box_width-1:0] box_x_out,
   output logic      [box_width-1:0] box_y_out,
   output logic                      optical_tx_enable_out,
   output logic                      contact_active_out,
   output logic                      lock_status_output_out,
   output logic                      irq_out
);
   // every check samples on the one clock and sleeps through reset
   default clocking @(posedge clk_in);
   endclocking
   default disable iff (!nrst_in);

   // refuse sizes that the status word or the box bounce cannot serve
   if (second_cycles < 1 || box_cycles < 1 || fmt_width < 1 || fmt_width > 4 ||
       box_width < 2) begin : g_bad_param
      $error("unsupported parameter values");
   end

   typedef struct packed {
      logic [11:0]          ctrl;
      logic [2:0]           irq_en;
      logic [2:0]           irq_stat;
      sdi_fallback_pkg::mode_t mode;
      logic [31:0]          sec_cnt;
      logic [2:0]           secs_left;
      logic                 lock_d;
      logic [fmt_width-1:0] fmt;
      logic [31:0]          box_cnt;
      logic [box_width-1:0] bx;
      logic [box_width-1:0] by;
      logic                 dx;
      logic                 dy;
      logic                 ack;
      logic [31:0]          rdata;
   } state_t;

   state_t st;
   state_t next_st;

   logic                 sel_opt;
   logic                 sel_lock;
   logic [fmt_width-1:0] sel_fmt;
   logic                 follow;
   logic                 reference_only_mode;
   logic [2:0]           delay;
   logic                 overlay;
   logic                 pol_low;
   logic                 loss_ev;
   logic                 lock_ev;
   logic [2:0]           events;
   logic [2:0]           clr;

   //////////////////////////////////////////////////////////////////////////
   // configuration decode and receiver select
   assign sel_opt  = st.ctrl[sdi_fallback_pkg::ctrl_input_bit];
   assign follow   = st.ctrl[sdi_fallback_pkg::ctrl_follow_bit];
   assign delay    = st.ctrl[sdi_fallback_pkg::ctrl_delay_lsb +: 3];
   assign overlay  = st.ctrl[sdi_fallback_pkg::ctrl_overlay_bit];
   assign reference_only_mode  = st.ctrl[sdi_fallback_pkg::ctrl_reference_only_mode_bit];
   assign pol_low  = st.ctrl[sdi_fallback_pkg::ctrl_pol_bit];
   // only the chosen receiver is looked at; no auto failover
   assign sel_lock = sel_opt ? opt_lock_in : coax_lock_in;
   assign sel_fmt  = sel_opt ? opt_fmt_in : coax_fmt_in;
   // loss is lock falling, relock is lock rising
   assign loss_ev  = st.lock_d & ~sel_lock;
   assign lock_ev  = ~st.lock_d & sel_lock;

   //////////////////////////////////////////////////////////////////////////
   // next-state logic
   always_comb begin
      next_st = st;
      events  = 3'h0;
      clr     = 3'h0;
      next_st.lock_d = sel_lock;
      next_st.ack    = 1'b0;
      // bus: one wait cycle, answer on the second cycle
      if ((avs_read_in || avs_write_in) && !st.ack) begin
         next_st.ack = 1'b1;
         if (avs_write_in) begin
            if (avs_address_in == sdi_fallback_pkg::ctrl_offset) begin
               next_st.ctrl = avs_writedata_in[11:0];
            end else if (avs_address_in == sdi_fallback_pkg::irq_en_offset) begin
               next_st.irq_en = avs_writedata_in[2:0];
            end else if (avs_address_in == sdi_fallback_pkg::irq_clr_offset) begin
               clr = avs_writedata_in[2:0];
            end
         end
         if (avs_address_in == sdi_fallback_pkg::ctrl_offset) begin
            next_st.rdata = {20'h0, st.ctrl};
         end else if (avs_address_in == sdi_fallback_pkg::status_offset) begin
            next_st.rdata = {20'h0, 4'(st.fmt), 2'(st.mode), 1'b0, sel_lock,
                             ~contact_input_in, st.irq_stat};
         end else if (avs_address_in == sdi_fallback_pkg::irq_en_offset) begin
            next_st.rdata = {29'h0, st.irq_en};
         end else begin
            next_st.rdata = 32'h0;
         end
      end
      // learn format while locked in follow mode only
      if (follow && sel_lock) begin
         next_st.fmt = sel_fmt;
      end
      // fallback sequence
      case (st.mode)
         sdi_fallback_pkg::st_pass: begin
            if (loss_ev || !sel_lock) begin
               events[sdi_fallback_pkg::ev_loss] = loss_ev;
               next_st.sec_cnt = 32'h0;
               if (delay == 3'h0) begin
                  next_st.mode = sdi_fallback_pkg::st_image;
                  events[sdi_fallback_pkg::ev_image] = 1'b1;
               end else begin
                  next_st.mode      = sdi_fallback_pkg::st_gray;
                  next_st.secs_left = delay;
               end
            end
         end
         sdi_fallback_pkg::st_gray: begin
            if (sel_lock) begin
               next_st.mode = sdi_fallback_pkg::st_pass;
            end else if (st.sec_cnt == 32'(second_cycles - 1)) begin
               next_st.sec_cnt = 32'h0;
               // whole seconds counted down
               if (st.secs_left == 3'h1) begin
                  next_st.mode = sdi_fallback_pkg::st_image;
                  events[sdi_fallback_pkg::ev_image] = 1'b1;
               end else begin
                  next_st.secs_left = st.secs_left - 3'h1;
               end
            end else begin
               next_st.sec_cnt = st.sec_cnt + 32'h1;
            end
         end
         sdi_fallback_pkg::st_image: begin
            if (sel_lock) begin
               next_st.mode = sdi_fallback_pkg::st_pass;
            end
         end
         default: begin
            next_st.mode = sdi_fallback_pkg::st_pass;
         end
      endcase
      events[sdi_fallback_pkg::ev_lock] = lock_ev;
      // box bounces a step per tick, slow enough to read as moving_box_overlay
      if (st.box_cnt == 32'(box_cycles - 1)) begin
         next_st.box_cnt = 32'h0;
         next_st.bx = st.dx ? st.bx - box_width'(1) : st.bx + box_width'(1);
         next_st.by = st.dy ? st.by - box_width'(1) : st.by + box_width'(1);
         if (!st.dx && st.bx == {{(box_width-1){1'b1}}, 1'b0}) next_st.dx = 1'b1;
         if (st.dx && st.bx == box_width'(1)) next_st.dx = 1'b0;
         if (!st.dy && st.by == {{(box_width-1){1'b1}}, 1'b0}) next_st.dy = 1'b1;
         if (st.dy && st.by == box_width'(1)) next_st.dy = 1'b0;
      end else begin
         next_st.box_cnt = st.box_cnt + 32'h1;
      end
      // set wins over clear
      next_st.irq_stat = (st.irq_stat & ~clr) | events;
   end

   //////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st      <= '0;
         st.ctrl <= sdi_fallback_pkg::ctrl_reset;
      end else begin
         st <= next_st;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // outputs
   assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !st.ack;
   assign avs_readdata_out    = st.rdata;
   always_comb begin
      // reference-only never shows input video
      if (st.mode == sdi_fallback_pkg::st_pass && !reference_only_mode) begin
         out_source_out = 2'(sdi_fallback_pkg::src_pass);
      end else if (st.mode == sdi_fallback_pkg::st_gray) begin
         out_source_out = 2'(sdi_fallback_pkg::src_gray);
      end else begin
         out_source_out = 2'(sdi_fallback_pkg::src_image);
      end
   end
   assign gen_fmt_out      = st.fmt;
   assign gen_ref_lock_out = reference_only_mode & sel_lock;
   // box only over stored image
   assign box_enable_out   = overlay && out_source_out == 2'(sdi_fallback_pkg::src_image);
   assign box_x_out        = st.bx;
   assign box_y_out        = st.by;
   assign optical_tx_enable_out = 1'b1;
   // level only, low is active; drives nothing in video
   assign contact_active_out = ~contact_input_in;
   // polarity select
   assign lock_status_output_out = sel_lock ^ pol_low;
   assign irq_out = |(st.irq_stat & st.irq_en);

   //////////////////////////////////////////////////////////////////////////
   // assertions
   a_gray_to_pass: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (st.mode == sdi_fallback_pkg::st_gray && sel_lock) |=> st.mode == sdi_fallback_pkg::st_pass)
      else $error("relock did not restore pass");
   a_zero_delay: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (st.mode == sdi_fallback_pkg::st_pass && !sel_lock && delay == 3'h0)
      |=> st.mode == sdi_fallback_pkg::st_image)
      else $error("no immediate image");
   a_gray_first: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (st.mode == sdi_fallback_pkg::st_pass && !sel_lock && delay != 3'h0)
      |=> st.mode == sdi_fallback_pkg::st_gray)
      else $error("gray skipped");
   a_fixed_fmt: assert property (@(posedge clk_in) disable iff (!nrst_in)
      !follow |=> st.fmt == $past(st.fmt))
      else $error("fixed format changed");
   a_status_pol: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (!pol_low && (sel_opt ? opt_lock_in : coax_lock_in)) |-> lock_status_output_out)
      else $error("status polarity wrong");
   a_reference_only_mode_src: assert property (@(posedge clk_in) disable iff (!nrst_in)
      reference_only_mode |-> out_source_out != 2'(sdi_fallback_pkg::src_pass))
      else $error("input video in reference mode");
   a_box_off: assert property (@(posedge clk_in) disable iff (!nrst_in)
      !overlay |-> !box_enable_out)
      else $error("box shown with overlay off");
   a_opt_tx: assert property (@(posedge clk_in) disable iff (!nrst_in)
      optical_tx_enable_out)
      else $error("optical output disabled");

   //////////////////////////////////////////////////////////////////////////
   // check helpers: mode flags and counter end points
   logic pass_now;
   logic gray_now;
   logic image_now;
   logic sec_end;
   logic box_end;
   assign pass_now  = st.mode == sdi_fallback_pkg::st_pass;
   assign gray_now  = st.mode == sdi_fallback_pkg::st_gray;
   assign image_now = st.mode == sdi_fallback_pkg::st_image;
   assign sec_end   = st.sec_cnt == 32'(second_cycles - 1);
   assign box_end   = st.box_cnt == 32'(box_cycles - 1);
   // status pin follows the chosen receiver and the polarity bit
   a_coax_status: assert property (
      !sel_opt
      |-> lock_status_output_out == (coax_lock_in ^ pol_low))
      else $error("status not from coaxial receiver");
   a_opt_status: assert property (
      sel_opt
      |-> lock_status_output_out == (opt_lock_in ^ pol_low))
      else $error("status not from optical receiver");
   a_input_kept: assert property (
      !(avs_write_in && !st.ack && avs_address_in == sdi_fallback_pkg::ctrl_offset)
      |=> $stable(sel_opt))
      else $error("receiver changed without a write");
   a_status_low: assert property (
      (pol_low && sel_lock)
      |-> !lock_status_output_out)
      else $error("active-low status high while locked");
   a_status_high: assert property (
      (pol_low && !sel_lock)
      |-> lock_status_output_out)
      else $error("active-low status low while unlocked");
   a_unlock_low: assert property (
      (!pol_low && !sel_lock)
      |-> !lock_status_output_out)
      else $error("active-high status high while unlocked");
   // contact pin: level only, and no say over the video path
   a_contact_level: assert property (
      !contact_input_in
      |-> contact_active_out)
      else $error("low contact not seen as active");
   a_contact_idle: assert property (
      contact_input_in
      |-> !contact_active_out)
      else $error("released contact seen as active");
   a_contact_inert: assert property (
      (!contact_input_in && pass_now && sel_lock)
      |=> pass_now)
      else $error("contact disturbed pass-through");
   // format learning and the gray countdown
   a_follow_fmt: assert property (
      (follow && sel_lock)
      |=> st.fmt == $past(sel_fmt))
      else $error("format not learned");
   a_fmt_kept: assert property (
      !sel_lock
      |=> $stable(st.fmt))
      else $error("learned format lost");
   a_gray_src: assert property (
      gray_now
      |-> out_source_out == 2'(sdi_fallback_pkg::src_gray))
      else $error("gray state not showing gray");
   a_gray_count: assert property (
      (gray_now && !sel_lock && !sec_end)
      |=> gray_now && st.sec_cnt == $past(st.sec_cnt) + 32'h1)
      else $error("second counter stalled");
   a_gray_second: assert property (
      (gray_now && !sel_lock && sec_end && st.secs_left != 3'h1)
      |=> gray_now && st.secs_left == $past(st.secs_left) - 3'h1)
      else $error("seconds not counted down");
   a_gray_end: assert property (
      (gray_now && !sel_lock && sec_end && st.secs_left == 3'h1)
      |=> image_now)
      else $error("gray interval overran");
   a_image_holds: assert property (
      (image_now && !sel_lock)
      |=> image_now)
      else $error("stored image dropped without lock");
   a_gray_load: assert property (
      (pass_now && !sel_lock && delay != 3'h0)
      |=> st.secs_left == $past(delay))
      else $error("gray length not loaded");
   a_gray_nonzero: assert property (
      gray_now
      |-> st.secs_left != 3'h0)
      else $error("gray with zero seconds left");
   // box moving_box_overlay and output source
   a_box_image: assert property (
      (overlay && out_source_out == 2'(sdi_fallback_pkg::src_image))
      |-> box_enable_out)
      else $error("box missing over stored image");
   a_box_only: assert property (
      out_source_out != 2'(sdi_fallback_pkg::src_image)
      |-> !box_enable_out)
      else $error("box outside stored image");
   a_box_still: assert property (
      !box_end
      |=> $stable(st.bx) && $stable(st.by))
      else $error("box moved between ticks");
   a_box_step: assert property (
      box_end
      |=> st.bx != $past(st.bx) && st.by != $past(st.by))
      else $error("box did not step");
   a_pass_src: assert property (
      (pass_now && !reference_only_mode)
      |-> out_source_out == 2'(sdi_fallback_pkg::src_pass))
      else $error("input not passed through");
   a_ref_lock: assert property (
      reference_only_mode
      |-> gen_ref_lock_out == sel_lock)
      else $error("reference lock not followed");
   a_image_relock: assert property (
      (image_now && sel_lock)
      |=> pass_now)
      else $error("relock did not leave stored image");
   a_loss_flag: assert property (
      loss_ev
      |=> st.irq_stat[sdi_fallback_pkg::ev_loss])
      else $error("loss not flagged");
   // interrupts and bus handshake
   a_irq_level: assert property (
      (st.irq_stat & st.irq_en) != 3'h0
      |-> irq_out)
      else $error("enabled event without interrupt");
   a_bus_answer: assert property (
      avs_waitrequest_out
      |=> !avs_waitrequest_out)
      else $error("more than one wait cycle");
endmodule
`default_nettype wire

// ===== hdl/sdi_fallback_pkg.sv
// constants and types shared by the fallback output controller
// Overview of operation
// - contact input counts as asserted only while its pin is low, level only
// - video input taken from coaxial or optical receiver per configuration bit
// - exactly one input active; never switch receivers automatically
// - follow mode: generator adopts and remembers input format and rate
// - fixed mode: generator format and rate never change with the input
// - on input loss output solid gray before the stored image
// - gray interval lasts a whole number of seconds, one to seven
// - gray interval disabled: stored image starts at once on loss
// - delay setting is 0 to 7 seconds, zero meaning no gray
// - overlay on: red box moves slowly over the stored image
// - overlay off: stored image output without the box
// - normal mode passes a valid selected input through unchanged
// - reference-only: input gives timing and format, never video content
// - optical output always enabled, same data as coaxial output
// - lock status output reflects lock of the selected receiver
// - active-high polarity: status high while locked, else low
// - active-low polarity: status low while locked, else high
// - contact input has no effect on video output
package sdi_fallback_pkg;
   // register byte offsets
   localparam logic [3:0] ctrl_offset    = 4'h0;
   localparam logic [3:0] status_offset  = 4'h4;
   localparam logic [3:0] irq_en_offset  = 4'h8;
   localparam logic [3:0] irq_clr_offset = 4'hC;
   // control field positions
   localparam int ctrl_input_bit   = 0;
   localparam int ctrl_follow_bit  = 1;
   localparam int ctrl_delay_lsb   = 2;
   localparam int ctrl_overlay_bit = 5;
   localparam int ctrl_reference_only_mode_bit = 6;
   localparam int ctrl_pol_bit     = 7;
   localparam int ctrl_fmt_lsb     = 8;
   localparam int ctrl_width       = 12;
   localparam logic [11:0] ctrl_reset = 12'h023;
   // interrupt event bits
   localparam int ev_loss  = 0;
   localparam int ev_lock  = 1;
   localparam int ev_image = 2;
   localparam int ev_width = 3;
   // timing
   localparam int clk_hz      = 20_000_000;
   localparam int second_s    = 1;
   localparam int second_cyc  = clk_hz * second_s;
   localparam int box_step_hz = 60;
   localparam int box_cyc     = clk_hz / box_step_hz;
   // output source
   typedef enum logic [1:0] {src_pass, src_gray, src_image} src_t;
   // fallback state
   typedef enum logic [1:0] {st_pass, st_gray, st_image} mode_t;
endpackage
